// File: core/tpb_pkg.sv
/*
 * constants, register map and mode encodings of the timer channel
 * configuration block.
 * assumes a 32-bit classic wishbone bus with byte addresses.
 */
package tpb_pkg;
	// ------------------------------------------------------------
	// channel layout
	// ------------------------------------------------------------
	localparam int NUM_CH   = 6;
	localparam int NUM_CD   = 2;
	localparam int CD_CH0   = 0;
	localparam int CD_CH1   = 3;
	localparam int CLK_CH   = 5;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_BASE = 8'h00;
	localparam logic [7:0] IOAB_BASE = 8'h20;
	localparam logic [7:0] IOCD_CH0  = 8'h40;
	localparam logic [7:0] IOCD_CH3  = 8'h44;
	localparam logic [7:0] RUN_OFS   = 8'h50;
	localparam logic [7:0] CKS_OFS   = 8'h54;

	// ------------------------------------------------------------
	// mode register fields and reset values
	// ------------------------------------------------------------
	localparam int MODE_BUF_B  = 5;
	localparam int MODE_BUF_A  = 4;
	localparam int MODE_TOP    = 3;
	localparam int MODE_PHASE  = 2;
	localparam logic [1:0] MODE_FIXED = 2'h3;
	localparam logic [5:0] MODE_RST   = 6'h00;
	localparam logic [7:0] IO_RST     = 8'h00;
	localparam logic [2:0] CKS_RST    = 3'h0;

	// ------------------------------------------------------------
	// io control code fields
	// ------------------------------------------------------------
	localparam int IO_CAPTURE = 3;
	localparam int IO_INIT    = 2;
	localparam logic [1:0] IO_OFF    = 2'h0;
	localparam logic [1:0] IO_LOW    = 2'h1;
	localparam logic [1:0] IO_HIGH   = 2'h2;
	localparam logic [1:0] IO_TOGGLE = 2'h3;

	// ------------------------------------------------------------
	// channel 5 clock select codes and divider taps
	// ------------------------------------------------------------
	localparam logic [2:0] CKS_DIV1   = 3'h0;
	localparam logic [2:0] CKS_DIV4   = 3'h1;
	localparam logic [2:0] CKS_DIV16  = 3'h2;
	localparam logic [2:0] CKS_DIV64  = 3'h3;
	localparam logic [2:0] CKS_EXT_A  = 3'h4;
	localparam logic [2:0] CKS_EXT_C  = 3'h5;
	localparam logic [2:0] CKS_DIV256 = 3'h6;
	localparam logic [2:0] CKS_EXT_D  = 3'h7;
	localparam int LOG_DIV4   = 2;
	localparam int LOG_DIV16  = 4;
	localparam int LOG_DIV64  = 6;
	localparam int LOG_DIV256 = 8;

	// ------------------------------------------------------------
	// decoded operating modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TPB_NORMAL,
		TPB_PWM1,
		TPB_PWM2,
		TPB_PHASE1,
		TPB_PHASE2,
		TPB_PHASE3,
		TPB_PHASE4
	} tpb_mode_e;
endpackage : tpb_pkg

// File: core/tpb_ch5_clk.sv
/*
 * count clock enable for channel 5: prescaler taps and external
 * clock edges, chosen by the clock select code.
 * assumes the external clock inputs are synchronous to mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module tpb_ch5_clk #(
	parameter int DIV_W = tpb_pkg::LOG_DIV256
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// configuration
	input  wire logic [2:0] clk_sel,
	input  wire logic       phase_mode,
	input  wire logic       run,
	// external clocks
	input  wire logic       ext_clock_in_a,
	input  wire logic       ext_clock_in_c,
	input  wire logic       ext_clock_in_d,
	// count enable
	output logic            count_en_q
);
	logic [DIV_W-1:0] div_q;
	logic [2:0]       ext_prev_q;
	logic             rise_a;
	logic             rise_c;
	logic             rise_d;
	logic             tick_d;

	// ------------------------------------------------------------
	// free-running prescaler and edge detect
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;

	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			ext_prev_q <= 3'h0;
		else
			ext_prev_q <= {ext_clock_in_d, ext_clock_in_c,
				ext_clock_in_a};

	assign rise_a = ext_clock_in_a & ~ext_prev_q[0];
	assign rise_c = ext_clock_in_c & ~ext_prev_q[1];
	assign rise_d = ext_clock_in_d & ~ext_prev_q[2];

	// ------------------------------------------------------------
	// source select
	// ------------------------------------------------------------
	always_comb
	begin
		case (clk_sel)
			tpb_pkg::CKS_DIV1:   tick_d = 1'b1;
			tpb_pkg::CKS_DIV4:   tick_d = &div_q[tpb_pkg::LOG_DIV4-1:0];
			tpb_pkg::CKS_DIV16:  tick_d = &div_q[tpb_pkg::LOG_DIV16-1:0];
			tpb_pkg::CKS_DIV64:  tick_d = &div_q[tpb_pkg::LOG_DIV64-1:0];
			tpb_pkg::CKS_DIV256: tick_d = &div_q;
			tpb_pkg::CKS_EXT_A:  tick_d = rise_a;
			tpb_pkg::CKS_EXT_C:  tick_d = rise_c;
			tpb_pkg::CKS_EXT_D:  tick_d = rise_d;
			default:             tick_d = 1'b0;
		endcase
	end

	// phase counting takes its count from the phase inputs instead
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			count_en_q <= 1'b0;
		else
			count_en_q <= run & ~phase_mode & tick_d;
endmodule : tpb_ch5_clk
`default_nettype wire

// File: core/tpb_mode_io_cfg.sv
/*
 * mode, buffer and io control registers of a six channel timer,
 * with pin level control and the channel 5 count enable.
 * assumes a classic wishbone master and compare match and counter
 * clear pulses from the counter datapath, synchronous to mclk.
 */
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - codes 0-3 divide clock by 1,4,16,64
// - code 110 divides clock by 256
// - codes 100,101,111 count external clocks A,C,D
// - phase counting ignores the clock select
// - one mode register per channel
// - mode bits 7,6 read one, unwritable
// - buffer B makes D a buffer, no events
// - buffer A makes C a buffer, no events
// - buffer bits fixed zero without C/D
// - mode codes decode normal, pwm, phase
// - channels 0,3 have no phase counting
// - eight io control registers in total
// - initial level driven while counter stopped
// - pwm mode 2 sets level on clear
// - buffered C/D ignore their io setting
// - primary io register holds B and A codes
// - secondary register holds D and C codes
// - io code selects compare or capture role
module tpb_mode_io_cfg #(
	parameter int NCH = tpb_pkg::NUM_CH
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// counter datapath events
	input  wire logic [2*NCH-1:0]  cmp_match,
	input  wire logic [NCH-1:0]    cnt_clear,
	// external clocks
	input  wire logic              ext_clock_in_a,
	input  wire logic              ext_clock_in_c,
	input  wire logic              ext_clock_in_d,
	// channel configuration
	output logic      [3*NCH-1:0]  ch_mode,
	output logic      [NCH-1:0]    counter_run_bit,
	output logic      [NCH-1:0]    buffer_mode_a,
	output logic      [NCH-1:0]    buffer_mode_b,
	output logic      [2*NCH-1:0]  capture_sel,
	output logic      [15:0]       cd_code,
	output logic      [3:0]        cd_event_en,
	output logic                   ch5_count_en,
	output logic                   ch5_phase,
	// compare output pins a and b
	output logic      [2*NCH-1:0]  pin_out,
	output logic      [2*NCH-1:0]  pin_oe
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [5:0]      mode_q [NCH];
	logic [7:0]      ioab_q [NCH];
	logic [7:0]      iocd_q [tpb_pkg::NUM_CD];
	logic [NCH-1:0]  run_q;
	logic [2:0]      cks_q;
	logic            ack_q;
	logic [31:0]     dat_q;
	logic [31:0]     rd_d;
	logic            req;
	logic            wr;
	logic [3*NCH-1:0] mode_o_q;
	logic [NCH-1:0]  bufa_q;
	logic [NCH-1:0]  bufb_q;
	logic [2*NCH-1:0] cap_q;
	logic [2*NCH-1:0] lvl_q;
	logic [2*NCH-1:0] oe_q;
	logic [15:0]     cd_q;
	logic [3:0]      cd_en_q;
	logic            ph5_q;

	function automatic tpb_pkg::tpb_mode_e decode(input logic [3:0] m);
		if (m[tpb_pkg::MODE_TOP])
			return tpb_pkg::TPB_NORMAL;
		case (m[2:0])
			3'h2:    return tpb_pkg::TPB_PWM1;
			3'h3:    return tpb_pkg::TPB_PWM2;
			3'h4:    return tpb_pkg::TPB_PHASE1;
			3'h5:    return tpb_pkg::TPB_PHASE2;
			3'h6:    return tpb_pkg::TPB_PHASE3;
			3'h7:    return tpb_pkg::TPB_PHASE4;
			default: return tpb_pkg::TPB_NORMAL;
		endcase
	endfunction : decode

	// ------------------------------------------------------------
	// wishbone handshake
	// ------------------------------------------------------------
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr  = req & wb_we_i & wb_sel_i[0];

	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			ack_q <= 1'b0;
		else
			ack_q <= req;

	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			dat_q <= 32'h0;
		else if (req)
			dat_q <= rd_d;

	always_comb
	begin
		rd_d = 32'h0;
		for (int i = 0; i < NCH; i++)
		begin
			if (wb_adr_i == 8'(tpb_pkg::MODE_BASE + 4 * i))
				rd_d = {24'h0, tpb_pkg::MODE_FIXED, mode_q[i]};
			if (wb_adr_i == 8'(tpb_pkg::IOAB_BASE + 4 * i))
				rd_d = {24'h0, ioab_q[i]};
		end
		if (wb_adr_i == tpb_pkg::IOCD_CH0)
			rd_d = {24'h0, iocd_q[0]};
		if (wb_adr_i == tpb_pkg::IOCD_CH3)
			rd_d = {24'h0, iocd_q[1]};
		if (wb_adr_i == tpb_pkg::RUN_OFS)
			rd_d = {26'h0, run_q};
		if (wb_adr_i == tpb_pkg::CKS_OFS)
			rd_d = {29'h0, cks_q};
	end

	// ------------------------------------------------------------
	// run and clock select registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			run_q <= '0;
		else if (wr && wb_adr_i == tpb_pkg::RUN_OFS)
			run_q <= wb_dat_i[NCH-1:0];

	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			cks_q <= tpb_pkg::CKS_RST;
		else if (wr && wb_adr_i == tpb_pkg::CKS_OFS)
			cks_q <= wb_dat_i[2:0];

	// ------------------------------------------------------------
	// per channel mode, io control and pins
	// ------------------------------------------------------------
	for (genvar i = 0; i < NCH; i++)
	begin : g_ch
		localparam bit HAS_CD = (i == tpb_pkg::CD_CH0) ||
			(i == tpb_pkg::CD_CH1);
		localparam logic [7:0] MODE_A = 8'(tpb_pkg::MODE_BASE + 4 * i);
		localparam logic [7:0] IOAB_A = 8'(tpb_pkg::IOAB_BASE + 4 * i);
		logic [5:0]          wmask;
		tpb_pkg::tpb_mode_e  md;

		// buffer bits exist only with C/D, phase only without them
		assign wmask = HAS_CD ? 6'h3b : 6'h0f;
		assign md    = decode(mode_q[i][3:0]);

		always_ff @(posedge mclk or negedge rstn)
			if (!rstn)
				mode_q[i] <= tpb_pkg::MODE_RST;
			else if (wr && wb_adr_i == MODE_A)
				mode_q[i] <= wb_dat_i[5:0] & wmask;

		always_ff @(posedge mclk or negedge rstn)
			if (!rstn)
				ioab_q[i] <= tpb_pkg::IO_RST;
			else if (wr && wb_adr_i == IOAB_A)
				ioab_q[i] <= wb_dat_i[7:0];

		always_ff @(posedge mclk or negedge rstn)
			if (!rstn)
			begin
				mode_o_q[3*i +: 3] <= 3'(tpb_pkg::TPB_NORMAL);
				bufa_q[i]          <= 1'b0;
				bufb_q[i]          <= 1'b0;
			end
			else
			begin
				mode_o_q[3*i +: 3] <= 3'(md);
				bufa_q[i] <= mode_q[i][tpb_pkg::MODE_BUF_A];
				bufb_q[i] <= mode_q[i][tpb_pkg::MODE_BUF_B];
			end

		for (genvar k = 0; k < 2; k++)
		begin : g_ab
			localparam int P = 2 * i + k;
			logic [3:0] code;

			assign code = ioab_q[i][4*k +: 4];

			always_ff @(posedge mclk or negedge rstn)
				if (!rstn)
				begin
					cap_q[P] <= 1'b0;
					oe_q[P]  <= 1'b0;
				end
				else
				begin
					cap_q[P] <= code[tpb_pkg::IO_CAPTURE];
					oe_q[P]  <= ~code[tpb_pkg::IO_CAPTURE] &
						(code[1:0] != tpb_pkg::IO_OFF);
				end

			always_ff @(posedge mclk or negedge rstn)
				if (!rstn)
					lvl_q[P] <= 1'b0;
				else if (!run_q[i])
					lvl_q[P] <= code[tpb_pkg::IO_INIT];
				else if (md == tpb_pkg::TPB_PWM2 && cnt_clear[i])
					lvl_q[P] <= code[tpb_pkg::IO_INIT];
				else if (cmp_match[P] && !code[tpb_pkg::IO_CAPTURE])
				begin
					case (code[1:0])
						tpb_pkg::IO_LOW:    lvl_q[P] <= 1'b0;
						tpb_pkg::IO_HIGH:   lvl_q[P] <= 1'b1;
						tpb_pkg::IO_TOGGLE: lvl_q[P] <= ~lvl_q[P];
						default:            lvl_q[P] <= lvl_q[P];
					endcase
				end
		end
	end

	// ------------------------------------------------------------
	// secondary io control for channels with C/D
	// ------------------------------------------------------------
	for (genvar j = 0; j < tpb_pkg::NUM_CD; j++)
	begin : g_cd
		localparam int CH = (j == 0) ? tpb_pkg::CD_CH0 : tpb_pkg::CD_CH1;
		localparam logic [7:0] ADR = (j == 0) ? tpb_pkg::IOCD_CH0 :
			tpb_pkg::IOCD_CH3;
		logic use_c;
		logic use_d;

		assign use_c = ~mode_q[CH][tpb_pkg::MODE_BUF_A];
		assign use_d = ~mode_q[CH][tpb_pkg::MODE_BUF_B];

		always_ff @(posedge mclk or negedge rstn)
			if (!rstn)
				iocd_q[j] <= tpb_pkg::IO_RST;
			else if (wr && wb_adr_i == ADR)
				iocd_q[j] <= wb_dat_i[7:0];

		// buffered register: code ignored, events suppressed
		always_ff @(posedge mclk or negedge rstn)
			if (!rstn)
			begin
				cd_q[8*j +: 8]    <= 8'h00;
				cd_en_q[2*j +: 2] <= 2'h0;
			end
			else
			begin
				cd_q[8*j+4 +: 4] <= use_d ? iocd_q[j][7:4] : 4'h0;
				cd_q[8*j +: 4]   <= use_c ? iocd_q[j][3:0] : 4'h0;
				cd_en_q[2*j+1]   <= use_d;
				cd_en_q[2*j]     <= use_c;
			end
	end

	// ------------------------------------------------------------
	// channel 5 count clock
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			ph5_q <= 1'b0;
		else
			ph5_q <= mode_q[tpb_pkg::CLK_CH][tpb_pkg::MODE_PHASE] &
				~mode_q[tpb_pkg::CLK_CH][tpb_pkg::MODE_TOP];

	tpb_ch5_clk #(
		.DIV_W (tpb_pkg::LOG_DIV256)
	) u_clk5 (
		.mclk           (mclk),
		.rstn           (rstn),
		.clk_sel        (cks_q),
		.phase_mode     (ph5_q),
		.run            (run_q[tpb_pkg::CLK_CH]),
		.ext_clock_in_a (ext_clock_in_a),
		.ext_clock_in_c (ext_clock_in_c),
		.ext_clock_in_d (ext_clock_in_d),
		.count_en_q     (ch5_count_en)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign wb_dat_o        = dat_q;
	assign wb_ack_o        = ack_q;
	assign ch_mode         = mode_o_q;
	assign counter_run_bit = run_q;
	assign buffer_mode_a   = bufa_q;
	assign buffer_mode_b   = bufb_q;
	assign capture_sel     = cap_q;
	assign cd_code         = cd_q;
	assign cd_event_en     = cd_en_q;
	assign ch5_phase       = ph5_q;
	assign pin_out         = lvl_q;
	assign pin_oe          = oe_q;
endmodule : tpb_mode_io_cfg
`default_nettype wire

// File: verification/tpb_mode_io_cfg_props.sv
/*
 * concurrent checks on the ports of the timer channel configuration.
 * assumes it is bound into tpb_mode_io_cfg, one mclk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module tpb_mode_io_cfg_props #(
	parameter int NCH = tpb_pkg::NUM_CH
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// bus
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_ack_o,
	// configuration
	input  wire logic [3*NCH-1:0]  ch_mode,
	input  wire logic [NCH-1:0]    counter_run_bit,
	input  wire logic [NCH-1:0]    buffer_mode_a,
	input  wire logic [NCH-1:0]    buffer_mode_b,
	input  wire logic [15:0]       cd_code,
	input  wire logic [3:0]        cd_event_en,
	input  wire logic              ch5_count_en,
	input  wire logic              ch5_phase
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");
	property p_ack_resp;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp)
		else $error("request not answered next cycle");

	// ------------------------------------------------------------
	// channel 5 count enable
	// ------------------------------------------------------------
	property p_stop_cnt;
		!counter_run_bit[5] [*3] |-> !ch5_count_en;
	endproperty
	a_stop_cnt: assert property (p_stop_cnt)
		else $error("channel 5 counts while stopped");
	property p_phase_cnt;
		ch5_phase [*3] |-> !ch5_count_en;
	endproperty
	a_phase_cnt: assert property (p_phase_cnt)
		else $error("clock select used in phase mode");

	// ------------------------------------------------------------
	// buffer and mode fields
	// ------------------------------------------------------------
	property p_buf_fixed;
		((buffer_mode_a | buffer_mode_b) & 6'h36) == 6'h00;
	endproperty
	a_buf_fixed: assert property (p_buf_fixed)
		else $error("buffer bit set on channel without c/d");
	property p_buf_a;
		buffer_mode_a[0] [*2] |-> !cd_event_en[0] && cd_code[3:0] == 4'h0;
	endproperty
	a_buf_a: assert property (p_buf_a)
		else $error("buffered c register still active");
	property p_buf_b;
		buffer_mode_b[3] [*2] |-> !cd_event_en[3] && cd_code[15:12] == 4'h0;
	endproperty
	a_buf_b: assert property (p_buf_b)
		else $error("buffered d register still active");
	property p_no_phase03;
		ch_mode[2:0] < 3'h3 && ch_mode[11:9] < 3'h3;
	endproperty
	a_no_phase03: assert property (p_no_phase03)
		else $error("phase mode on channel 0 or 3");
	property p_mode_code;
		ch_mode[5:3] != 3'h7 && ch_mode[17:15] != 3'h7;
	endproperty
	a_mode_code: assert property (p_mode_code)
		else $error("undefined mode decode");
endmodule : tpb_mode_io_cfg_props

bind tpb_mode_io_cfg tpb_mode_io_cfg_props #(.NCH(NCH))
	u_tpb_mode_io_cfg_props (
	.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .ch_mode(ch_mode),
	.counter_run_bit(counter_run_bit), .buffer_mode_a(buffer_mode_a),
	.buffer_mode_b(buffer_mode_b), .cd_code(cd_code),
	.cd_event_en(cd_event_en), .ch5_count_en(ch5_count_en),
	.ch5_phase(ch5_phase)
);
`default_nettype wire

// File: verification/tpb_mode_io_cfg_test.sv
/*
 * register level testbench of the timer channel configuration.
 * assumes the register map of tpb_pkg and a 100 MHz mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module tpb_mode_io_cfg_test;
	logic        mclk = 1'b0, rstn = 1'b0;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
	logic [3:0]  wb_sel_i = 4'h0, cd_event_en;
	logic        wb_ack_o, ch5_count_en, ch5_phase;
	logic [11:0] cmp_match = 12'h000, capture_sel, pin_out, pin_oe;
	logic [5:0]  cnt_clear = 6'h00, counter_run_bit;
	logic [5:0]  buffer_mode_a, buffer_mode_b;
	logic [2:0]  ext_q = 3'h0;
	logic [17:0] ch_mode;
	logic [15:0] cd_code;
	int          err_count = 0, check_count = 0, pulse_cnt = 0, i, j;
	logic [2:0]  mode_exp [9] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
		3'h5, 3'h6, 3'h0};
	logic [2:0]  cks_code [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
	int          cks_n [5] = '{512, 128, 32, 8, 2};
	logic [2:0]  ext_code [3] = '{3'h4, 3'h5, 3'h7};

	tpb_mode_io_cfg u_tpb_mode_io_cfg (
		.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.cmp_match(cmp_match), .cnt_clear(cnt_clear),
		.ext_clock_in_a(ext_q[0]), .ext_clock_in_c(ext_q[1]),
		.ext_clock_in_d(ext_q[2]), .ch_mode(ch_mode),
		.counter_run_bit(counter_run_bit), .buffer_mode_a(buffer_mode_a),
		.buffer_mode_b(buffer_mode_b), .capture_sel(capture_sel),
		.cd_code(cd_code), .cd_event_en(cd_event_en),
		.ch5_count_en(ch5_count_en), .ch5_phase(ch5_phase),
		.pin_out(pin_out), .pin_oe(pin_oe)
	);

	always #5 mclk = ~mclk;
	always @(posedge mclk)
		if (ch5_count_en === 1'b1)
			pulse_cnt <= pulse_cnt + 1;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task print_verdict;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task chk(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, d, input logic [3:0] s);
		int n;
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= s;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			chk("ack timeout", 32'h0, 32'h1);
		rd_q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask : wb

	task wr(input logic [7:0] a, d);
		wb(1'b1, a, d, 4'h1);
	endtask : wr

	task rd(input string name, input logic [7:0] a, exp);
		wb(1'b0, a, 8'h00, 4'h1);
		chk(name, rd_q, {24'h0, exp});
	endtask : rd

	task settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle

	task pulse(input logic [11:0] m, input logic [5:0] c);
		@(posedge mclk);
		cmp_match <= m;
		cnt_clear <= c;
		@(posedge mclk);
		cmp_match <= 12'h000;
		cnt_clear <= 6'h00;
		settle;
	endtask : pulse

	task count_win(input int n, exp);
		int base;
		settle;
		base = pulse_cnt;
		repeat (n) @(posedge mclk);
		#1;
		chk("count", pulse_cnt - base, exp);
	endtask : count_win

	task ext_run(input int k, exp);
		int base;
		settle;
		base = pulse_cnt;
		repeat (5)
		begin
			@(posedge mclk);
			ext_q <= 3'(1 << k);
			repeat (2) @(posedge mclk);
			ext_q <= 3'h0;
			@(posedge mclk);
		end
		settle;
		chk("ext count", pulse_cnt - base, exp);
	endtask : ext_run

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial
	begin
		#200000;
		err_count++;
		print_verdict;
	end

	initial
	begin
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		for (i = 0; i < 6; i++)
			rd("mode reset", 8'(4 * i), 8'hc0);
		for (i = 0; i < 6; i++)
		begin
			wr(8'(4 * i), 8'hff);
			rd("mode ff", 8'(4 * i),
				(i % 3 == 0) ? 8'hfb : 8'hcf);
			wr(8'(4 * i), 8'h00);
		end
		for (i = 0; i < 9; i++)
		begin
			wr(8'h04, 8'(i));
			settle;
			chk("ch_mode", ch_mode[5:3], mode_exp[i]);
		end
		wr(8'h00, 8'h04);
		settle;
		chk("ch0 mode", ch_mode[2:0], 3'h0);
		for (i = 0; i < 8; i++)
		begin
			j = (i < 6) ? 8'h20 + 4 * i : 8'h40 + 4 * (i - 6);
			rd("io reset", 8'(j), 8'h00);
			wr(8'(j), 8'ha5);
			rd("io rw", 8'(j), 8'ha5);
		end
		settle;
		chk("capture_sel", capture_sel, 12'haaa);
		rd("unmapped", 8'h60, 8'h00);
		wb(1'b1, 8'h20, 8'h00, 4'h0);
		rd("sel dropped", 8'h20, 8'ha5);
		wr(8'h24, 8'h05);
		settle;
		chk("init level", {pin_oe[2], pin_out[2]}, 2'b11);
		wr(8'h50, 8'h02);
		pulse(12'h004, 6'h00);
		chk("match level", pin_out[2], 1'b0);
		wr(8'h50, 8'h00);
		settle;
		chk("stop level", pin_out[2], 1'b1);
		wr(8'h04, 8'h03);
		wr(8'h50, 8'h02);
		pulse(12'h004, 6'h00);
		chk("pwm2 match", pin_out[2], 1'b0);
		pulse(12'h000, 6'h02);
		chk("pwm2 clear", pin_out[2], 1'b1);
		wr(8'h24, 8'h07);
		pulse(12'h004, 6'h00);
		chk("toggle level", pin_out[2], 1'b0);
		wr(8'h24, 8'h02);
		pulse(12'h004, 6'h00);
		chk("high level", pin_out[2], 1'b1);
		wr(8'h40, 8'h55);
		wr(8'h44, 8'h77);
		wr(8'h00, 8'h10);
		wr(8'h0c, 8'h20);
		settle;
		chk("buffered cd", cd_code, 16'h0750);
		chk("buffered en", {cd_event_en[3], cd_event_en[0]},
			2'b00);
		chk("buf bits", {buffer_mode_b, buffer_mode_a},
			12'h201);
		wr(8'h00, 8'h00);
		wr(8'h0c, 8'h00);
		settle;
		chk("plain cd", cd_code, 16'h7755);
		wr(8'h50, 8'h20);
		rd("run reg", 8'h50, 8'h20);
		chk("run bits", counter_run_bit, 6'h20);
		for (i = 0; i < 5; i++)
		begin
			wr(8'h54, 8'(cks_code[i]));
			count_win(512, cks_n[i]);
		end
		for (i = 0; i < 3; i++)
			for (j = 0; j < 3; j++)
			begin
				wr(8'h54, 8'(ext_code[i]));
				ext_run(j, (i == j) ? 5 : 0);
			end
		wr(8'h54, 8'h00);
		wr(8'h50, 8'h00);
		wr(8'h14, 8'h04);
		wr(8'h50, 8'h20);
		count_win(64, 0);
		chk("phase", ch5_phase, 1'b1);
		print_verdict;
	end
endmodule : tpb_mode_io_cfg_test
`default_nettype wire
